// ### rtl/tx_pattern_gen.sv
// Transmit test pattern generator with output polarity inversion.
// Assumes all link controls and the receive error flag are on clk_sys.
//
// Contract
// - Select 1..5 pick PRBS-7/9/15/23/31
// - Select zero passes user data through
// - PRBS-7 uses taps 6 and 7
// - PRBS-9 uses taps 5 and 9
// - PRBS-15 uses taps 14 and 15
// - PRBS-23 uses taps 18 and 23
// - PRBS-31 uses taps 28 and 31
// - Compliance pattern only in 20/40/80 widths; the controller allows it in any width that is a multiple of 20
// - Compliance repeats K28.5- D21.5 K28.5+ D10.2
// - Select 1001 gives 2-UI square wave
// - Select 1010 gives word-width square wave
// - One bit error per inject cycle
// - Inject ignored while passing user data
// - Loop bit picks receive flag as inject
// - Outside converter mode, just change select
// - Converter mode: reset, reconfigure, select, release
// - Return to converter mode by reverse sequence
// - Invert input flips every outgoing bit
// - Inverted PRBS comes from invert input
`timescale 1ns/10ps
`default_nettype none
module tx_pattern_gen #(
  parameter int DATA_W = 20
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              srst,
  // Link from the controller
  pattern_link_if.gen            link,
  // Receive checker feedback
  input  wire logic              rx_pattern_error_flag,
  input  wire logic              rx_error_to_tx_inject_loop,
  // Outgoing line word, bit 0 leaves first
  output logic [DATA_W-1:0]      line_word
);

  localparam int SYMS_PER_WORD = DATA_W / pattern_pkg::SYM_BITS;
  localparam logic [1:0] SYM_STEP = 2'(SYMS_PER_WORD);

  // One Fibonacci step: feedback is the XOR of the two tap stages
  function automatic logic [30:0] prbs_step(input logic [30:0] s, input logic [4:0] len,
                                            input logic [4:0] tap);
    logic fb;
    fb = s[len - 5'h01] ^ s[tap - 5'h01];
    return {s[29:0], fb};
  endfunction : prbs_step

  // Mask of the stages in use for a polynomial length
  function automatic logic [30:0] len_mask(input logic [4:0] len);
    logic [31:0] m;
    m = (32'h1 << len) - 32'h1;
    return m[30:0];
  endfunction : len_mask

  // Compliance symbol by position in the four-symbol cycle
  function automatic logic [9:0] comp_sym(input logic [1:0] idx);
    logic [9:0] s;
    case (idx)
      2'h0:    s = pattern_pkg::SYM_K285_NEG;
      2'h1:    s = pattern_pkg::SYM_D215;
      2'h2:    s = pattern_pkg::SYM_K285_POS;
      default: s = pattern_pkg::SYM_D102;
    endcase
    return s;
  endfunction : comp_sym

  // Registers
  logic [30:0]       lfsr_q;
  logic [30:0]       lfsr_d;
  logic [3:0]        sel_q;
  logic [1:0]        sym_idx_q;
  logic [DATA_W-1:0] line_q;
  logic [2:0]        done_cnt_q;
  logic              done_q;
  logic              pcs_rst_q;

  // Select decode
  wire logic [3:0] sel = link.tx_pattern_select;
  wire logic is_prbs = (sel >= pattern_pkg::SEL_PRBS7) && (sel <= pattern_pkg::SEL_PRBS31);
  wire logic is_comp = (sel == pattern_pkg::SEL_COMPLIANCE);
  wire logic is_sq2  = (sel == pattern_pkg::SEL_SQUARE_2UI);
  wire logic is_sqw  = (sel == pattern_pkg::SEL_SQUARE_W);
  // Anything else, zero included, is standard operation
  wire logic gen_on  = is_prbs || is_comp || is_sq2 || is_sqw;

  // Polynomial per select
  wire logic [4:0] poly_len =
    (sel == pattern_pkg::SEL_PRBS7)  ? pattern_pkg::LEN_PRBS7  :
    (sel == pattern_pkg::SEL_PRBS9)  ? pattern_pkg::LEN_PRBS9  :
    (sel == pattern_pkg::SEL_PRBS15) ? pattern_pkg::LEN_PRBS15 :
    (sel == pattern_pkg::SEL_PRBS23) ? pattern_pkg::LEN_PRBS23 :
                                       pattern_pkg::LEN_PRBS31;
  wire logic [4:0] poly_tap =
    (sel == pattern_pkg::SEL_PRBS7)  ? pattern_pkg::TAP_PRBS7  :
    (sel == pattern_pkg::SEL_PRBS9)  ? pattern_pkg::TAP_PRBS9  :
    (sel == pattern_pkg::SEL_PRBS15) ? pattern_pkg::TAP_PRBS15 :
    (sel == pattern_pkg::SEL_PRBS23) ? pattern_pkg::TAP_PRBS23 :
                                       pattern_pkg::TAP_PRBS31;

  // Dead state is any state with all used stages zero
  wire logic lfsr_dead = ((lfsr_q & len_mask(poly_len)) == 31'h0);
  wire logic reseed    = lfsr_dead || (sel != sel_q) || pcs_rst_q;

  // Serialise the register into one word, oldest stage first
  logic [DATA_W-1:0] prbs_word;
  always_comb begin
    logic [30:0] s;
    s = reseed ? pattern_pkg::PRBS_SEED : lfsr_q;
    prbs_word = '0;
    for (int i = 0; i < DATA_W; i++) begin
      prbs_word[i] = s[poly_len - 5'h01];
      s = prbs_step(s, poly_len, poly_tap);
    end
    lfsr_d = s;
  end

  // Compliance word; bits past the last whole symbol stay zero
  logic [DATA_W-1:0] comp_word;
  always_comb begin
    comp_word = '0;
    for (int k = 0; k < SYMS_PER_WORD; k++) begin
      comp_word[k*pattern_pkg::SYM_BITS +: pattern_pkg::SYM_BITS] =
        comp_sym(2'(sym_idx_q + 2'(k)));
    end
  end

  // Square waves: alternate every UI, or half a word low then half high
  logic [DATA_W-1:0] sq2_word;
  logic [DATA_W-1:0] sqw_word;
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      sq2_word[i] = (i % 2) == 1;
      sqw_word[i] = i >= (DATA_W / 2);
    end
  end

  // Pattern selection
  wire logic [DATA_W-1:0] pat_word =
    is_prbs ? prbs_word :
    is_comp ? comp_word :
    is_sq2  ? sq2_word  :
    is_sqw  ? sqw_word  :
              link.tx_parallel_word;

  // Error source: receive flag when looped, else the link input
  wire logic inject_src = rx_error_to_tx_inject_loop ? rx_pattern_error_flag
                                                     : link.tx_pattern_error_inject;
  // One flipped bit per cycle, never on user data
  wire logic [DATA_W-1:0] err_mask = {{(DATA_W-1){1'b0}}, inject_src && gen_on};
  // Polarity flip applies to user data and patterns alike
  wire logic [DATA_W-1:0] inv_mask = {DATA_W{link.tx_output_invert}};
  wire logic [DATA_W-1:0] out_word = pat_word ^ err_mask ^ inv_mask;

  // Generator state; coding-sublayer reset holds a selected PRBS one word past the seed and the symbol index at start
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lfsr_q    <= pattern_pkg::PRBS_SEED;
      sel_q     <= pattern_pkg::SEL_OFF;
      sym_idx_q <= 2'h0;
      pcs_rst_q <= 1'b1;
    end else begin
      pcs_rst_q <= link.tx_coding_sublayer_reset;
      sel_q     <= sel;
      if (is_prbs) begin
        lfsr_q <= lfsr_d;
      end
      if (pcs_rst_q || !is_comp) begin
        sym_idx_q <= 2'h0;
      end else begin
        sym_idx_q <= sym_idx_q + SYM_STEP;
      end
    end
  end

  // Output word; quiet zero while the coding sublayer is held in reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      line_q <= '0;
    end else if (pcs_rst_q) begin
      line_q <= '0;
    end else begin
      line_q <= out_word;
    end
  end

  // Reset-complete rises a fixed count after the reset is released
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      done_cnt_q <= 3'h0;
      done_q     <= 1'b0;
    end else if (link.tx_coding_sublayer_reset) begin
      done_cnt_q <= 3'h0;
      done_q     <= 1'b0;
    end else if (done_cnt_q != 3'(pattern_pkg::RESET_DONE_CYCLES)) begin
      done_cnt_q <= done_cnt_q + 3'h1;
    end else begin
      done_q <= 1'b1;
    end
  end

  assign line_word              = line_q;
  assign link.tx_reset_complete = done_q;

endmodule : tx_pattern_gen
`default_nettype wire

// ### inc/pattern_pkg.sv
// Shared constants for the transmit test pattern generator and its controller.
// Assumes both ends run on clk_sys and see the same pattern select encoding.
package pattern_pkg;

  // Pattern select encodings
  localparam logic [3:0] SEL_OFF        = 4'h0;
  localparam logic [3:0] SEL_PRBS7      = 4'h1;
  localparam logic [3:0] SEL_PRBS9      = 4'h2;
  localparam logic [3:0] SEL_PRBS15     = 4'h3;
  localparam logic [3:0] SEL_PRBS23     = 4'h4;
  localparam logic [3:0] SEL_PRBS31     = 4'h5;
  localparam logic [3:0] SEL_COMPLIANCE = 4'h8;
  localparam logic [3:0] SEL_SQUARE_2UI = 4'h9;
  localparam logic [3:0] SEL_SQUARE_W   = 4'ha;

  // Polynomial lengths and second taps (1 + X^tap + X^len)
  localparam logic [4:0] LEN_PRBS7  = 5'h07;
  localparam logic [4:0] TAP_PRBS7  = 5'h06;
  localparam logic [4:0] LEN_PRBS9  = 5'h09;
  localparam logic [4:0] TAP_PRBS9  = 5'h05;
  localparam logic [4:0] LEN_PRBS15 = 5'h0f;
  localparam logic [4:0] TAP_PRBS15 = 5'h0e;
  localparam logic [4:0] LEN_PRBS23 = 5'h17;
  localparam logic [4:0] TAP_PRBS23 = 5'h12;
  localparam logic [4:0] LEN_PRBS31 = 5'h1f;
  localparam logic [4:0] TAP_PRBS31 = 5'h1c;
  localparam logic [30:0] PRBS_SEED = 31'h7fffffff;

  // Compliance symbols, in transmit order
  localparam logic [9:0] SYM_K285_NEG = 10'h0fa; // 0011111010
  localparam logic [9:0] SYM_D215     = 10'h2aa; // 1010101010
  localparam logic [9:0] SYM_K285_POS = 10'h305; // 1100000101
  localparam logic [9:0] SYM_D102     = 10'h155; // 0101010101
  localparam int         SYM_BITS     = 10;
  localparam int         COMPLIANCE_STEP = 20;   // width must be a multiple of this

  // Output clock source codes
  localparam logic [2:0] CLK_SRC_SERIALIZER = 3'h2;
  localparam logic [2:0] CLK_SRC_PROG_DIV   = 3'h5;

  // Count reached after coding-sublayer reset release; reset-complete rises one cycle after it
  localparam int RESET_DONE_CYCLES = 4;

  // Controller register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Control register fields
  localparam int CTRL_SEL_LSB   = 0;
  localparam int CTRL_INJECT    = 4;
  localparam int CTRL_INVERT    = 5;
  localparam int CTRL_LOOP      = 6;
  localparam int CTRL_CONV_MODE = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register fields
  localparam int STAT_BUSY     = 0;
  localparam int STAT_DONE     = 1;
  localparam int STAT_CONV     = 2;
  localparam int STAT_SEL_LSB  = 3;

endpackage : pattern_pkg

// ### inc/pattern_link_if.sv
// Link between the transmit controller and the pattern generator.
// Assumes both ends are clocked by the same clk_sys; no clocking block.
`timescale 1ns/10ps
`default_nettype none
interface pattern_link_if #(parameter int DATA_W = 20);
  logic [3:0]        tx_pattern_select;
  logic              tx_pattern_error_inject;
  logic              tx_output_invert;
  logic [DATA_W-1:0] tx_parallel_word;
  logic              tx_coding_sublayer_reset;
  logic              tx_async_width_converter_on;
  logic              tx_elastic_buffer_on;
  logic [2:0]        tx_out_clock_source;
  logic              tx_reset_complete;

  modport gen (
    input  tx_pattern_select, tx_pattern_error_inject, tx_output_invert,
    input  tx_parallel_word, tx_coding_sublayer_reset,
    input  tx_async_width_converter_on, tx_elastic_buffer_on, tx_out_clock_source,
    output tx_reset_complete
  );

  modport ctrl (
    output tx_pattern_select, tx_pattern_error_inject, tx_output_invert,
    output tx_parallel_word, tx_coding_sublayer_reset,
    output tx_async_width_converter_on, tx_elastic_buffer_on, tx_out_clock_source,
    input  tx_reset_complete
  );
endinterface : pattern_link_if
`default_nettype wire

// ### rtl/tx_pattern_ctrl.sv
// Controller end: APB registers that drive the pattern generator link.
// Assumes an APB master on clk_sys and the generator on the other end of the link.
`timescale 1ns/10ps
`default_nettype none
module tx_pattern_ctrl #(
  parameter int DATA_W = 20
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              srst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // User data to send in standard operation
  input  wire logic [DATA_W-1:0] user_word,
  // Link to the generator
  pattern_link_if.ctrl           link
);

  // Reconfiguration sequence, Gray coded from idle to wait; the return to idle flips two bits
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_RESET   = 3'h1,
    ST_BUFFER  = 3'h3,
    ST_CLOCK   = 3'h2,
    ST_SELECT  = 3'h6,
    ST_RELEASE = 3'h7,
    ST_WAIT    = 3'h5
  } seq_type;

  localparam bit COMP_OK = (DATA_W % pattern_pkg::COMPLIANCE_STEP) == 0;

  seq_type           st_q;
  logic [7:0]        ctrl_q;
  logic [3:0]        sel_q;
  logic              conv_q;
  logic              buf_q;
  logic [2:0]        clk_src_q;
  logic              pcs_rst_q;
  logic [DATA_W-1:0] word_q;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;

  // Bus decode
  wire logic setup    = psel && !penable;
  wire logic access   = psel && penable && pready_q;
  wire logic hit_ctrl = paddr == pattern_pkg::OFS_CTRL;
  wire logic hit_cmd  = paddr == pattern_pkg::OFS_CMD;
  wire logic hit_stat = paddr == pattern_pkg::OFS_STATUS;
  wire logic mapped   = hit_ctrl || hit_cmd || hit_stat;
  wire logic busy     = st_q != ST_IDLE;
  wire logic start    = access && pwrite && hit_cmd && pwdata[0] && !busy;

  // Requested pattern; compliance refused where the width cannot carry it
  wire logic [3:0] req_sel = ctrl_q[pattern_pkg::CTRL_SEL_LSB +: 4];
  wire logic [3:0] safe_sel = (req_sel == pattern_pkg::SEL_COMPLIANCE && !COMP_OK)
                              ? pattern_pkg::SEL_OFF : req_sel;
  wire logic want_conv = ctrl_q[pattern_pkg::CTRL_CONV_MODE];

  wire logic [31:0] status_word = {25'h0, sel_q, conv_q, link.tx_reset_complete, busy};
  wire logic [31:0] read_word = hit_ctrl ? {24'h0, ctrl_q} : hit_stat ? status_word : 32'h0;

  // APB answer: data and ready prepared in the setup cycle, zero wait states
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q  <= setup ? read_word : 32'h0;
    end
  end

  // Control register; the command bit is not stored
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_q <= pattern_pkg::CTRL_RESET;
    end else if (access && pwrite && hit_ctrl) begin
      ctrl_q <= pwdata[7:0];
    end
  end

  // Sequence: reset, converter and buffer, clock source, select, release, wait
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q      <= ST_IDLE;
      sel_q     <= pattern_pkg::SEL_OFF;
      conv_q    <= 1'b0;
      buf_q     <= 1'b1;
      clk_src_q <= pattern_pkg::CLK_SRC_SERIALIZER;
      pcs_rst_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            st_q <= ST_RESET;
          end else if (!conv_q) begin
            sel_q <= safe_sel;
          end
        end
        ST_RESET: begin
          pcs_rst_q <= 1'b1;
          st_q      <= ST_BUFFER;
        end
        ST_BUFFER: begin
          conv_q <= want_conv;
          buf_q  <= !want_conv;
          st_q   <= ST_CLOCK;
        end
        ST_CLOCK: begin
          clk_src_q <= want_conv ? pattern_pkg::CLK_SRC_PROG_DIV
                                 : pattern_pkg::CLK_SRC_SERIALIZER;
          st_q      <= ST_SELECT;
        end
        ST_SELECT: begin
          sel_q <= want_conv ? pattern_pkg::SEL_OFF : safe_sel;
          st_q  <= ST_RELEASE;
        end
        ST_RELEASE: begin
          pcs_rst_q <= 1'b0;
          st_q      <= ST_WAIT;
        end
        ST_WAIT: begin
          // The generator drops done within a cycle of the reset, so no stale pass
          if (link.tx_reset_complete) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // User data retimed so every link output leaves a flip-flop
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      word_q <= '0;
    end else begin
      word_q <= user_word;
    end
  end

  assign prdata                           = prdata_q;
  assign pready                           = pready_q;
  assign pslverr                          = pslverr_q;
  assign link.tx_pattern_select           = sel_q;
  assign link.tx_pattern_error_inject     = ctrl_q[pattern_pkg::CTRL_INJECT];
  assign link.tx_output_invert            = ctrl_q[pattern_pkg::CTRL_INVERT];
  assign link.tx_parallel_word            = word_q;
  assign link.tx_coding_sublayer_reset    = pcs_rst_q;
  assign link.tx_async_width_converter_on = conv_q;
  assign link.tx_elastic_buffer_on        = buf_q;
  assign link.tx_out_clock_source         = clk_src_q;

endmodule : tx_pattern_ctrl
`default_nettype wire

// ### tb/tx_test_pattern_generator_props.sv
// Checker for the link and line word between controller and generator.
// Assumes instantiation beside the link interface, every input named as its signal.
`timescale 1ns/10ps
`default_nettype none
module tx_test_pattern_generator_props #(
  parameter int DATA_W = 20
) (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              srst,
  // Link signals
  input wire logic [3:0]        tx_pattern_select,
  input wire logic              tx_pattern_error_inject,
  input wire logic              tx_output_invert,
  input wire logic [DATA_W-1:0] tx_parallel_word,
  input wire logic              tx_coding_sublayer_reset,
  input wire logic              tx_async_width_converter_on,
  input wire logic              tx_elastic_buffer_on,
  input wire logic [2:0]        tx_out_clock_source,
  input wire logic              tx_reset_complete,
  // Generator side pins
  input wire logic              rx_pattern_error_flag,
  input wire logic              rx_error_to_tx_inject_loop,
  input wire logic [DATA_W-1:0] line_word
);
  localparam int DONE_MIN = 1;
  localparam int DONE_MAX = 8;
  logic gen_hold_q;

  // Mirror of the generator's one-cycle-late view of the coding reset
  always_ff @(posedge clk_sys) begin
    gen_hold_q <= srst ? 1'b1 : tx_coding_sublayer_reset;
  end

  // Masks laid over a word; inject lands on bit 0, invert goes last
  wire              inj_eff   = rx_error_to_tx_inject_loop ? rx_pattern_error_flag
                                                           : tx_pattern_error_inject;
  wire [DATA_W-1:0] flip_mask = {{(DATA_W-1){tx_output_invert}}, tx_output_invert ^ inj_eff};
  wire [DATA_W-1:0] pass_word = tx_parallel_word ^ {DATA_W{tx_output_invert}};
  wire [6:0]        seed_head = 7'h7f ^ flip_mask[6:0];
  wire              run       = !gen_hold_q;
  wire              reserved  = tx_pattern_select inside {4'h6, 4'h7} || tx_pattern_select > 4'ha;
  wire              prbs_sel  = tx_pattern_select inside {[4'h1:4'h5]};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_user_passthru: assert property (run && tx_pattern_select == 4'h0 |=>
    line_word == $past(pass_word)) else $error("user word not passed through");
  a_reserved_pass: assert property (run && reserved |=>
    line_word == $past(pass_word)) else $error("reserved select not passing user word");
  a_square_short: assert property (run && tx_pattern_select == 4'h9 |=>
    line_word == ({(DATA_W/2){2'b10}} ^ $past(flip_mask))) else $error("bad 2-UI square word");
  a_square_wide: assert property (run && tx_pattern_select == 4'ha |=>
    line_word == ({{(DATA_W/2){1'b1}}, {(DATA_W/2){1'b0}}} ^ $past(flip_mask)))
    else $error("bad word-width square word");
  a_prbs_reseed: assert property (run && prbs_sel && $changed(tx_pattern_select) |=>
    line_word[6:0] == $past(seed_head)) else $error("sequence did not restart from seed");
  a_quiet_reset: assert property (tx_coding_sublayer_reset [*2] |=> line_word == '0)
    else $error("line word not quiet in coding reset");
  a_done_drops: assert property (tx_coding_sublayer_reset |=> !tx_reset_complete)
    else $error("reset complete high during coding reset");
  a_done_returns: assert property ($fell(tx_coding_sublayer_reset) |->
    ##[DONE_MIN:DONE_MAX] tx_reset_complete) else $error("reset complete never returned");
  a_width_ok: assert property (tx_pattern_select == 4'h8 |-> DATA_W % 20 == 0)
    else $error("compliance pattern selected in unsupported width");
  a_conv_select_off: assert property (tx_async_width_converter_on &&
    !tx_coding_sublayer_reset |-> tx_pattern_select == 4'h0) else $error("pattern in converter mode");
  a_buffer_excl: assert property (tx_async_width_converter_on != tx_elastic_buffer_on)
    else $error("converter and buffer enables not complementary");
  a_clock_follows: assert property (!tx_coding_sublayer_reset |->
    tx_out_clock_source == (tx_async_width_converter_on ? 3'h5 : 3'h2))
    else $error("clock source does not match mode");
  a_seq_order: assert property ($rose(tx_coding_sublayer_reset) |->
    tx_coding_sublayer_reset [*3] ##[1:4] !tx_coding_sublayer_reset)
    else $error("coding reset not held through reconfiguration");
endmodule : tx_test_pattern_generator_props
`default_nettype wire

// ### tb/tb_tx_test_pattern_generator.sv
// Testbench joining controller and generator over the link, driven over APB.
// Assumes the package, interface, both ends and checker compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_tx_test_pattern_generator;
  localparam int W = 20;
  logic          clk_sys   = 1'b0;
  logic          srst      = 1'b1;
  logic          psel      = 1'b0;
  logic          penable   = 1'b0;
  logic          pwrite    = 1'b0;
  logic [7:0]    paddr     = 8'h00;
  logic [31:0]   pwdata    = 32'h0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [W-1:0]  user_word = 20'h12345;
  logic          loop_on   = 1'b0;
  logic          rx_flag   = 1'b1;
  logic [W-1:0]  line_word;
  logic [31:0]   rd;
  logic          err;
  int            fails = 0;
  int            total_checks = 0;
  int            lens[5] = '{7, 9, 15, 23, 31};
  int            taps[5] = '{6, 5, 14, 18, 28};
  // Rows: control byte, loop bit, expected steady word (user word held at 12345)
  logic [28:0]   rows[10] = '{{8'h00, 1'b0, 20'h12345}, {8'h10, 1'b0, 20'h12345},
    {8'h20, 1'b0, 20'hedcba}, {8'h16, 1'b0, 20'h12345}, {8'h1f, 1'b0, 20'h12345},
    {8'h09, 1'b0, 20'haaaaa}, {8'h19, 1'b0, 20'haaaab}, {8'h09, 1'b1, 20'haaaab},
    {8'h0a, 1'b0, 20'hffc00}, {8'h3a, 1'b0, 20'h003fe}};

  // Free-running 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;

  pattern_link_if #(.DATA_W(W)) pattern_link_if_i ();
  tx_pattern_ctrl #(.DATA_W(W)) tx_pattern_ctrl_i (.clk_sys(clk_sys), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .user_word(user_word),
    .link(pattern_link_if_i));
  tx_pattern_gen #(.DATA_W(W)) tx_pattern_gen_i (.clk_sys(clk_sys), .srst(srst),
    .link(pattern_link_if_i), .rx_pattern_error_flag(rx_flag),
    .rx_error_to_tx_inject_loop(loop_on), .line_word(line_word));
  tx_test_pattern_generator_props #(.DATA_W(W)) tx_test_pattern_generator_props_i (
    .clk_sys(clk_sys), .srst(srst),
    .tx_pattern_select(pattern_link_if_i.tx_pattern_select),
    .tx_pattern_error_inject(pattern_link_if_i.tx_pattern_error_inject),
    .tx_output_invert(pattern_link_if_i.tx_output_invert),
    .tx_parallel_word(pattern_link_if_i.tx_parallel_word),
    .tx_coding_sublayer_reset(pattern_link_if_i.tx_coding_sublayer_reset),
    .tx_async_width_converter_on(pattern_link_if_i.tx_async_width_converter_on),
    .tx_elastic_buffer_on(pattern_link_if_i.tx_elastic_buffer_on),
    .tx_out_clock_source(pattern_link_if_i.tx_out_clock_source),
    .tx_reset_complete(pattern_link_if_i.tx_reset_complete),
    .rx_pattern_error_flag(rx_flag), .rx_error_to_tx_inject_loop(loop_on),
    .line_word(line_word));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer, held until pready is sampled high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Bounded wait until the generator has taken a select, then one edge for its word
  task automatic wait_sel(input logic [3:0] s);
    for (int n = 0; n < 40 && pattern_link_if_i.tx_pattern_select !== s; n++) @(posedge clk_sys);
    @(posedge clk_sys);
  endtask : wait_sel

  // Start a sequence, poll status until idle; the poll bound is the bench's own
  task automatic sequence_run(input logic [31:0] ctrl);
    apb(1'b1, pattern_pkg::OFS_CTRL, ctrl);
    apb(1'b1, pattern_pkg::OFS_CMD, 32'h1);
    for (int n = 0; n < 30; n++) begin
      apb(1'b0, pattern_pkg::OFS_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
  endtask : sequence_run

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // Watchdog: the whole run needs well under 3000 cycles
  initial begin
    repeat (6000) @(posedge clk_sys);
    fails++;
    conclude();
  end

  // Main sequence
  initial begin
    logic [30:0]  sr;
    logic [W-1:0] exp;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    foreach (rows[r]) begin
      loop_on <= rows[r][20];
      apb(1'b1, pattern_pkg::OFS_CTRL, {24'h0, rows[r][28:21]});
      repeat (5) @(posedge clk_sys);
      check(32'(line_word), {12'h0, rows[r][19:0]});
    end
    // Looped with a quiet receive flag: the link inject must not reach the line
    rx_flag <= 1'b0;
    loop_on <= 1'b1;
    apb(1'b1, pattern_pkg::OFS_CTRL, 32'h19);
    repeat (5) @(posedge clk_sys);
    check(32'(line_word), 32'haaaaa);
    loop_on <= 1'b0;
    // Each sequence from an all-ones seed, three words deep
    for (int k = 0; k < 5; k++) begin
      sr = '1;
      apb(1'b1, pattern_pkg::OFS_CTRL, 32'(k + 1));
      wait_sel(4'(k + 1));
      repeat (3) begin
        for (int i = 0; i < W; i++) begin
          exp[i] = sr[lens[k]-1];
          sr = {sr[29:0], sr[lens[k]-1] ^ sr[taps[k]-1]};
        end
        check(32'(line_word), 32'(exp));
        @(posedge clk_sys);
      end
    end
    // Inverted PRBS comes from the invert bit: a fresh seed's leading ones go out as zeros
    apb(1'b1, pattern_pkg::OFS_CTRL, 32'h21);
    wait_sel(4'h1);
    check(32'(line_word[6:0]), 32'h0);
    apb(1'b1, pattern_pkg::OFS_CTRL, 32'h8);
    wait_sel(4'h8);
    check(32'(line_word), {12'h0, 10'h2aa, 10'h0fa});
    @(posedge clk_sys);
    check(32'(line_word), {12'h0, 10'h155, 10'h305});
    @(posedge clk_sys);
    check(32'(line_word), {12'h0, 10'h2aa, 10'h0fa});
    // Into converter mode and back: enables, clock source and select
    sequence_run(32'h81);
    check(32'(rd[2:1]), 32'h3);
    check({23'h0, pattern_link_if_i.tx_async_width_converter_on, pattern_link_if_i.tx_elastic_buffer_on,
      pattern_link_if_i.tx_out_clock_source, pattern_link_if_i.tx_pattern_select}, 32'h150);
    sequence_run(32'h05);
    check({23'h0, pattern_link_if_i.tx_async_width_converter_on, pattern_link_if_i.tx_elastic_buffer_on,
      pattern_link_if_i.tx_out_clock_source, pattern_link_if_i.tx_pattern_select}, 32'h0a5);
    // Unmapped offset is refused with an error response and zero data
    apb(1'b0, 8'h0c, 32'h0);
    check({rd[30:0], err}, 32'h1);
    // Second reset in mid-run: quiet line, cleared control, reset complete returns
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(32'(line_word), 32'h0);
    apb(1'b0, pattern_pkg::OFS_CTRL, 32'h0);
    check(rd, 32'h0);
    repeat (8) @(posedge clk_sys);
    apb(1'b0, pattern_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h2);
    conclude();
  end
endmodule : tb_tx_test_pattern_generator
`default_nettype wire
